// *** vsfsc_top.sv ***
// Sliced VBI data FIFO, status flags, interrupts and output steering
`timescale 1ns/100ps
module vsfsc_top (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    // Register port from the serial control interface
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // Interrupt enables and latched conditions
    input  wire logic [7:0] irq_en,
    output logic            irq_thr_sts,
    output logic            irq_line_sts,
    output logic            irq_req,
    // Video timing, from the video clock domain
    input  wire logic       vid_clk,
    input  wire logic       hsync_n,
    input  wire logic       vsync_n,
    input  wire logic       field_two,
    // Slicer results, from the video clock domain
    input  wire logic       sl_hdr,
    input  wire logic [2:0] sl_svc,
    input  wire logic [7:0] sl_len,
    input  wire logic       sl_dv,
    input  wire logic [7:0] sl_byte,
    // Slice mode selection
    input  wire logic [7:0] line_mode,
    input  wire logic [7:0] ff_mode,
    input  wire logic       in_vblank,
    output logic      [7:0] slice_mode,
    output logic            cfg_load,
    output logic            res_clear,
    // Video output byte lane
    output logic      [7:0] vo_data,
    output logic            vo_valid,
    input  wire logic       vo_ready
);
    localparam int SW = 25;

    // Two-stage synchroniser for every video-domain input
    logic [SW-1:0] async_in;
    logic [SW-1:0] sync1_r;
    logic [SW-1:0] sync2_r;
    assign async_in = {vid_clk, hsync_n, vsync_n, field_two, sl_hdr,
                       sl_svc, sl_len, sl_dv, sl_byte};
    genvar gi;
    generate
        for (gi = 0; gi < SW; gi++) begin : g_sync
            always_ff @(posedge clk_sys or negedge nrst) begin
                if (!nrst) begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                end else begin
                    sync1_r[gi] <= async_in[gi];
                    sync2_r[gi] <= sync1_r[gi];
                end
            end
        end
    endgenerate
    wire       vclk_s = sync2_r[24];
    wire       hs_s   = sync2_r[23];
    wire       vs_s   = sync2_r[22];
    wire       fld_s  = sync2_r[21];
    wire       hdr_s  = sync2_r[20];
    wire [2:0] svc_s  = sync2_r[19:17];
    wire [7:0] len_s  = sync2_r[16:9];
    wire       dv_s   = sync2_r[8];
    wire [7:0] byte_s = sync2_r[7:0];
    // Register state
    logic [7:0] thr_r;
    logic [7:0] line_int_r;
    logic [7:0] swpix_lo_r;
    logic [1:0] swpix_hi_r;
    logic       host_acc_r;
    logic       ff_en_r;
    logic       ferr_r;
    logic [5:0] avail_r;
    logic       thr_sts_r;
    logic       line_sts_r;
    logic [7:0] rdata_r;
    // Timing state
    logic       vclk_d_r;
    logic       hs_prev_r;
    logic       vs_prev_r;
    logic [9:0] pix_r;
    logic [9:0] line_r;
    logic       cfg_load_r;
    logic [7:0] slice_mode_r;
    logic       res_clear_r;
    // FIFO state
    logic [15:0]                   mem [0:255];
    logic [vsfsc_pkg::FIFO_AW-1:0] wr_ptr_r;
    logic [vsfsc_pkg::FIFO_AW-1:0] rd_ptr_r;
    logic [vsfsc_pkg::FIFO_CW-1:0] cnt_r;
    logic                          rd_lo_r;
    vsfsc_pkg::vsfsc_wr_state_t    wr_st_r;
    logic [7:0]                    remain_r;
    logic [2:0]                    svc_r;
    logic                          half_r;
    logic [7:0]                    hold_r;
    // Output buffer state
    logic [7:0] ob_mem [0:1];
    logic       ob_wp_r;
    logic       ob_rp_r;
    logic [1:0] ob_cnt_r;
    // Address decode
    wire wr_status = reg_wr & (reg_addr == vsfsc_pkg::ADDR_STATUS);
    wire wr_irq    = reg_wr & (reg_addr == vsfsc_pkg::ADDR_IRQ_STATUS);
    wire flush     = reg_wr & (reg_addr == vsfsc_pkg::ADDR_FLUSH);
    wire host_rd   = reg_rd & (reg_addr == vsfsc_pkg::ADDR_FIFO_DATA);
    // Video timing events, taken on sampled rising edges of the video clock
    wire vrise   = vclk_s & ~vclk_d_r;
    wire hs_fall = vrise & hs_prev_r & ~hs_s;
    wire vs_fall = vrise & vs_prev_r & ~vs_s;
    wire hdr_ev  = vrise & hdr_s;
    wire dv_ev   = vrise & dv_s & ~hdr_s;
    wire [9:0] swpix    = {swpix_hi_r, swpix_lo_r};
    wire [9:0] line_inc = line_r + 10'h001;
    wire [5:0] line_num = line_int_r[vsfsc_pkg::LI_NUM_W-1:0];
    wire       fld_en   = fld_s ? line_int_r[vsfsc_pkg::LI_F2_BIT]
                                : line_int_r[vsfsc_pkg::LI_F1_BIT];
    wire       line_hit = hs_fall & fld_en
                        & (line_inc == {4'h0, line_num})
                        & (line_num > vsfsc_pkg::LINE_NO_IRQ_MAX);
    // Space check for a whole line: header word plus rounded-up payload
    wire [8:0] len_words = ({1'b0, len_s} + 9'h001) >> 1;
    wire [8:0] need      = len_words + vsfsc_pkg::HEADER_WORDS;
    wire [8:0] free      = vsfsc_pkg::FIFO_DEPTH - cnt_r;
    wire       fits      = need <= free;
    wire       load      = wr_st_r == vsfsc_pkg::WR_LOAD;
    wire       last_byte = load & dv_ev & (remain_r == 8'h01);
    // Push selection: header word, odd last byte padded, or byte pair
    wire        push_hdr  = hdr_ev & fits;
    wire        push_pair = load & dv_ev & half_r;
    wire        push_odd  = last_byte & ~half_r;
    wire        push      = ~flush & (push_hdr | push_pair | push_odd);
    wire [15:0] push_data = push_hdr  ? {5'h00, svc_s, len_s} :
                            push_pair ? {hold_r, byte_s} :
                                        {byte_s, 8'h00};
    wire        ferr_set  = hdr_ev & ~fits;
    wire [5:0]  avail_set = ((last_byte | push_hdr & (len_s == 8'h00))
                             & ~flush) ? 6'(1 << (last_byte ? svc_r : svc_s))
                                       : 6'h00;
    // Read side: host register reads or the video lane drain
    wire       empty    = cnt_r == 9'h000;
    wire       ob_ready = ob_cnt_r != 2'h2;
    wire       take     = ~flush & ~empty
                        & (host_acc_r ? host_rd : ob_ready);
    wire [15:0] rd_word = mem[rd_ptr_r];
    wire [7:0]  rd_byte = rd_lo_r ? rd_word[7:0] : rd_word[15:8];
    wire        pop     = take & rd_lo_r;
    wire        ob_push = take & ~host_acc_r;
    wire        ob_pop  = vo_valid & vo_ready;

    wire [8:0] cnt_nxt  = cnt_r + {8'h00, push} - {8'h00, pop};
    wire [7:0] word_cnt = cnt_r[8] ? vsfsc_pkg::COUNT_SAT : cnt_r[7:0];

    // Status flags: a set in the clearing cycle wins
    wire [7:0] st_clr    = wr_status ? reg_wdata : 8'h00;
    wire       ferr_nxt  = (ferr_r & ~st_clr[vsfsc_pkg::ST_FULL_ERR])
                         | ferr_set;
    wire [5:0] avail_nxt = (avail_r & ~st_clr[5:0]) | avail_set;
    wire [7:0] irq_clr   = wr_irq ? reg_wdata : 8'h00;
    wire       thr_hit   = cnt_r > {1'b0, thr_r};
    wire       thr_nxt   = (thr_sts_r & ~irq_clr[vsfsc_pkg::IRQ_THR_BIT])
                         | thr_hit;
    wire       line_nxt  = (line_sts_r & ~irq_clr[vsfsc_pkg::IRQ_LINE_BIT])
                         | line_hit;
    // Per-line setting first, else full field, else no slicing
    wire       line_own  = in_vblank
                         & (line_mode != vsfsc_pkg::MODE_SLICE_OFF);
    wire [7:0] mode_nxt  = line_own ? line_mode :
                           ff_en_r  ? ff_mode :
                                      vsfsc_pkg::MODE_SLICE_OFF;
    // Register read mux
    wire [7:0] status_rd = {ferr_r, empty, avail_r};
    wire [7:0] rd_mux =
        (reg_addr == vsfsc_pkg::ADDR_STATUS)     ? status_rd :
        (reg_addr == vsfsc_pkg::ADDR_WORD_COUNT) ? word_cnt :
        (reg_addr == vsfsc_pkg::ADDR_THRESHOLD)  ? thr_r :
        (reg_addr == vsfsc_pkg::ADDR_LINE_INT)   ? line_int_r :
        (reg_addr == vsfsc_pkg::ADDR_SWPIX_LO)   ? swpix_lo_r :
        (reg_addr == vsfsc_pkg::ADDR_SWPIX_HI)   ? {6'h00, swpix_hi_r} :
        (reg_addr == vsfsc_pkg::ADDR_OUT_SEL)    ? {7'h00, host_acc_r} :
        (reg_addr == vsfsc_pkg::ADDR_FULL_FIELD) ? {7'h00, ff_en_r} :
        (reg_addr == vsfsc_pkg::ADDR_IRQ_STATUS) ?
            {5'h00, thr_sts_r, line_sts_r, 1'b0} :
        (host_rd & take)                         ? rd_byte : 8'h00;

    // Control registers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            thr_r      <= vsfsc_pkg::RST_THRESHOLD;
            line_int_r <= vsfsc_pkg::RST_LINE_INT;
            swpix_lo_r <= vsfsc_pkg::RST_SWPIX_LO;
            swpix_hi_r <= vsfsc_pkg::RST_SWPIX_HI;
            host_acc_r <= vsfsc_pkg::RST_HOST_ACCESS;
            ff_en_r    <= vsfsc_pkg::RST_FULL_FIELD;
        end else if (reg_wr) begin
            case (reg_addr)
                vsfsc_pkg::ADDR_THRESHOLD:  thr_r      <= reg_wdata;
                vsfsc_pkg::ADDR_LINE_INT:   line_int_r <= reg_wdata;
                vsfsc_pkg::ADDR_SWPIX_LO:   swpix_lo_r <= reg_wdata;
                vsfsc_pkg::ADDR_SWPIX_HI:   swpix_hi_r <= reg_wdata[1:0];
                vsfsc_pkg::ADDR_OUT_SEL:    host_acc_r <= reg_wdata[0];
                vsfsc_pkg::ADDR_FULL_FIELD: ff_en_r    <= reg_wdata[0];
                default: ;
            endcase
        end
    end

    // Flags and read data
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ferr_r     <= 1'b0;
            avail_r    <= 6'h00;
            thr_sts_r  <= 1'b0;
            line_sts_r <= 1'b0;
            rdata_r    <= 8'h00;
        end else begin
            ferr_r     <= flush ? 1'b0 : ferr_nxt;
            avail_r    <= flush ? 6'h00 : avail_nxt;
            thr_sts_r  <= thr_nxt;
            line_sts_r <= line_nxt;
            rdata_r    <= reg_rd ? rd_mux : rdata_r;
        end
    end

    // Pixel and line counting on the sampled video clock
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            vclk_d_r     <= 1'b0;
            hs_prev_r    <= 1'b1;
            vs_prev_r    <= 1'b1;
            pix_r        <= 10'h000;
            line_r       <= 10'h000;
            cfg_load_r   <= 1'b0;
            slice_mode_r <= vsfsc_pkg::MODE_SLICE_OFF;
            res_clear_r  <= 1'b0;
        end else begin
            vclk_d_r     <= vclk_s;
            hs_prev_r    <= vrise ? hs_s : hs_prev_r;
            vs_prev_r    <= vrise ? vs_s : vs_prev_r;
            pix_r        <= hs_fall ? 10'h000 :
                            vrise   ? pix_r + 10'h001 : pix_r;
            line_r       <= vs_fall ? 10'h000 :
                            hs_fall ? line_inc : line_r;
            cfg_load_r   <= vrise & ~hs_fall & (pix_r == swpix);
            slice_mode_r <= mode_nxt;
            res_clear_r  <= flush;
        end
    end

    // Line capture state machine
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wr_st_r  <= vsfsc_pkg::WR_IDLE;
            remain_r <= 8'h00;
            svc_r    <= 3'h0;
            half_r   <= 1'b0;
            hold_r   <= 8'h00;
        end else if (flush) begin
            wr_st_r <= vsfsc_pkg::WR_IDLE;
            half_r  <= 1'b0;
        end else if (hdr_ev) begin
            // A fresh header abandons any unfinished line
            wr_st_r  <= (fits & (len_s != 8'h00)) ? vsfsc_pkg::WR_LOAD
                      : fits ? vsfsc_pkg::WR_IDLE : vsfsc_pkg::WR_DROP;
            remain_r <= len_s;
            svc_r    <= svc_s;
            half_r   <= 1'b0;
        end else if (load & dv_ev) begin
            remain_r <= remain_r - 8'h01;
            half_r   <= ~half_r;
            hold_r   <= byte_s;
            wr_st_r  <= last_byte ? vsfsc_pkg::WR_IDLE : vsfsc_pkg::WR_LOAD;
        end
    end

    // FIFO pointers and occupancy
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r    <= '0;
            rd_lo_r  <= 1'b0;
        end else if (flush) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r    <= '0;
            rd_lo_r  <= 1'b0;
        end else begin
            wr_ptr_r <= push ? wr_ptr_r + 8'h01 : wr_ptr_r;
            rd_ptr_r <= pop ? rd_ptr_r + 8'h01 : rd_ptr_r;
            cnt_r    <= cnt_nxt;
            rd_lo_r  <= take ? ~rd_lo_r : rd_lo_r;
        end
    end

    // Storage has no reset; pointers define what is valid
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr_r] <= push_data;
        end
    end

    // Two-entry buffer before the video lane absorbs receiver stalls
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ob_wp_r  <= 1'b0;
            ob_rp_r  <= 1'b0;
            ob_cnt_r <= 2'h0;
        end else if (flush) begin
            ob_wp_r  <= 1'b0;
            ob_rp_r  <= 1'b0;
            ob_cnt_r <= 2'h0;
        end else begin
            ob_wp_r  <= ob_push ? ~ob_wp_r : ob_wp_r;
            ob_rp_r  <= ob_pop ? ~ob_rp_r : ob_rp_r;
            ob_cnt_r <= ob_cnt_r + {1'b0, ob_push} - {1'b0, ob_pop};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (ob_push) begin
            ob_mem[ob_wp_r] <= rd_byte;
        end
    end
    // Outputs
    assign reg_rdata    = rdata_r;
    assign irq_thr_sts  = thr_sts_r;
    assign irq_line_sts = line_sts_r;
    assign irq_req      = (thr_sts_r & irq_en[vsfsc_pkg::IRQ_THR_BIT])
                        | (line_sts_r & irq_en[vsfsc_pkg::IRQ_LINE_BIT]);
    assign slice_mode   = slice_mode_r;
    assign cfg_load     = cfg_load_r;
    assign res_clear    = res_clear_r;
    assign vo_valid     = ob_cnt_r != 2'h0;
    assign vo_data      = vo_valid ? ob_mem[ob_rp_r] : 8'h00;
endmodule

// *** vsfsc_pkg.sv ***
// Constants and types shared by the sliced-data FIFO and status block
package vsfsc_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_IRQ_STATUS  = 8'hc0;
    localparam logic [7:0] ADDR_STATUS      = 8'hc6;
    localparam logic [7:0] ADDR_WORD_COUNT  = 8'hc7;
    localparam logic [7:0] ADDR_THRESHOLD   = 8'hc8;
    localparam logic [7:0] ADDR_FLUSH       = 8'hc9;
    localparam logic [7:0] ADDR_LINE_INT    = 8'hca;
    localparam logic [7:0] ADDR_SWPIX_LO    = 8'hcb;
    localparam logic [7:0] ADDR_SWPIX_HI    = 8'hcc;
    localparam logic [7:0] ADDR_OUT_SEL     = 8'hcd;
    localparam logic [7:0] ADDR_FIFO_DATA   = 8'hce;
    localparam logic [7:0] ADDR_FULL_FIELD  = 8'hcf;

    // Field positions
    localparam int ST_FULL_ERR   = 7;
    localparam int ST_EMPTY      = 6;
    localparam int SVC_COUNT     = 6;
    localparam int IRQ_THR_BIT   = 2;
    localparam int IRQ_LINE_BIT  = 1;
    localparam int LI_F1_BIT     = 7;
    localparam int LI_F2_BIT     = 6;
    localparam int LI_NUM_W      = 6;
    localparam int SWPIX_HI_W    = 2;
    localparam int OUT_HOST_BIT  = 0;
    localparam int FF_EN_BIT     = 0;

    // Reset values
    localparam logic [7:0] RST_THRESHOLD   = 8'h80;
    localparam logic [7:0] RST_LINE_INT    = 8'h00;
    localparam logic [7:0] RST_SWPIX_LO    = 8'h4e;
    localparam logic [1:0] RST_SWPIX_HI    = 2'h0;
    localparam logic       RST_HOST_ACCESS = 1'b1;
    localparam logic       RST_FULL_FIELD  = 1'b0;

    // FIFO geometry: 16-bit words, one header word per stored line
    localparam int         FIFO_AW      = 8;
    localparam int         FIFO_CW      = 9;
    localparam logic [8:0] FIFO_DEPTH   = 9'h100;
    localparam logic [8:0] HEADER_WORDS = 9'h001;
    localparam logic [7:0] COUNT_SAT    = 8'hff;

    // Slice mode value meaning "no per-line setting"
    localparam logic [7:0] MODE_SLICE_OFF = 8'hff;
    // Programmed line numbers up to this value never match
    localparam logic [5:0] LINE_NO_IRQ_MAX = 6'h01;

    // Write-side line capture states
    typedef enum logic [2:0] {
        WR_IDLE = 3'b001,
        WR_LOAD = 3'b010,
        WR_DROP = 3'b100
    } vsfsc_wr_state_t;
endpackage

// *** vsfsc_sva.sv ***
// Port-level assertions for the sliced-data FIFO and status block
`timescale 1ns/100ps
module vsfsc_sva (
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       nrst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Interrupts
    input wire logic [7:0] irq_en,
    input wire logic       irq_thr_sts,
    input wire logic       irq_line_sts,
    input wire logic       irq_req,
    // Slice mode and video lane
    input wire logic [7:0] line_mode,
    input wire logic       in_vblank,
    input wire logic [7:0] slice_mode,
    input wire logic       cfg_load,
    input wire logic       res_clear,
    input wire logic [7:0] vo_data,
    input wire logic       vo_valid,
    input wire logic       vo_ready
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    wire fl_wr = reg_wr && reg_addr == vsfsc_pkg::ADDR_FLUSH;
    wire st_wr = reg_wr && reg_addr == vsfsc_pkg::ADDR_IRQ_STATUS;

    sequence flush_wr;
        reg_wr && reg_addr == vsfsc_pkg::ADDR_FLUSH;
    endsequence
    sequence stall_hold;
        vo_valid && !vo_ready && !fl_wr;
    endsequence

    a_flush_pulse: assert property (flush_wr |=> res_clear)
        else $error("flush write gave no result clear");
    a_clear_cause: assert property (res_clear |-> $past(fl_wr))
        else $error("result clear without flush write");
    a_irq_gate: assert property (irq_req ==
        ((irq_thr_sts && irq_en[2]) || (irq_line_sts && irq_en[1])))
        else $error("interrupt request not gated by enables");
    a_thr_hold: assert property
        (irq_thr_sts && !(st_wr && reg_wdata[2]) && !fl_wr |=> irq_thr_sts)
        else $error("threshold status dropped without clear");
    a_line_hold: assert property
        (irq_line_sts && !(st_wr && reg_wdata[1]) && !fl_wr |=> irq_line_sts)
        else $error("line status dropped without clear");
    a_vo_stall: assert property
        (stall_hold |=> vo_valid && $stable(vo_data))
        else $error("video byte lost during stall");
    a_vo_idle: assert property (!vo_valid |-> vo_data == 8'h00)
        else $error("video lane data while not valid");
    a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without read");
    a_mode_own: assert property
        (line_mode != 8'hff && in_vblank |=> slice_mode == $past(line_mode))
        else $error("per-line slice mode not applied");
    a_cfg_single: assert property (cfg_load |=> !cfg_load)
        else $error("configuration reload longer than one cycle");
endmodule

bind vsfsc_top vsfsc_sva u_sva (.clk_sys(clk_sys), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq_en(irq_en),
    .irq_thr_sts(irq_thr_sts), .irq_line_sts(irq_line_sts),
    .irq_req(irq_req), .line_mode(line_mode), .in_vblank(in_vblank),
    .slice_mode(slice_mode), .cfg_load(cfg_load), .res_clear(res_clear),
    .vo_data(vo_data), .vo_valid(vo_valid), .vo_ready(vo_ready));

// *** vsfsc_slicer_model.sv ***
// Video timing and slicer result source feeding the FIFO block
`timescale 1ns/100ps
module vsfsc_slicer_model (
    // Video timing
    output logic       vid_clk,
    output logic       hsync_n,
    output logic       vsync_n,
    output logic       field_two,
    // Slicer results
    output logic       sl_hdr,
    output logic [2:0] sl_svc,
    output logic [7:0] sl_len,
    output logic       sl_dv,
    output logic [7:0] sl_byte
);
    initial begin
        {vid_clk, sl_hdr, sl_dv, field_two} = 4'h0;
        {hsync_n, vsync_n} = 2'h3;
        sl_svc = 3'h0;
        sl_len = 8'h00;
        sl_byte = 8'h5a;
    end

    // Pixel clock runs free, as a decoder's line-locked clock does
    always #100 vid_clk = ~vid_clk;

    task automatic send_line(input logic [2:0] svc, input logic [7:0] len,
                             input logic [7:0] base);
        @(negedge vid_clk);
        sl_hdr <= 1'b1;
        sl_svc <= svc;
        sl_len <= len;
        @(negedge vid_clk);
        sl_hdr <= 1'b0;
        sl_len <= ~len;
        for (int i = 0; i < int'(len); i++) begin
            sl_dv <= 1'b1;
            sl_byte <= base + 8'(i);
            @(negedge vid_clk);
        end
        // Released lane shows the inverse so stale data never matches
        sl_dv <= 1'b0;
        sl_byte <= ~sl_byte;
        repeat (4) @(negedge vid_clk);
    endtask

    task automatic scan_field(input logic f2, input int lines);
        @(negedge vid_clk);
        field_two <= f2;
        vsync_n <= 1'b0;
        repeat (2) @(negedge vid_clk);
        vsync_n <= 1'b1;
        repeat (lines) begin
            hsync_n <= 1'b0;
            repeat (2) @(negedge vid_clk);
            hsync_n <= 1'b1;
            repeat (14) @(negedge vid_clk);
        end
    endtask
endmodule

// *** vsfsc_tb_top.sv ***
// Self-checking bench for the sliced-data FIFO and status block
`timescale 1ns/100ps
`define CHK(a, e) begin \
    check_count++; \
    if ((a) !== (e)) begin \
        miscompares++; \
        $display("BAD %0t got %0h exp %0h", $time, (a), (e)); \
    end \
end
module vsfsc_tb_top;
    logic       clk_sys, nrst, reg_wr, reg_rd, in_vblank, vo_ready;
    logic       vid_clk, hsync_n, vsync_n, field_two, sl_hdr, sl_dv;
    logic       irq_thr_sts, irq_line_sts, irq_req, cfg_load, res_clear;
    logic       vo_valid;
    logic [2:0] sl_svc;
    logic [7:0] reg_addr, reg_wdata, irq_en, line_mode, ff_mode, rd_v;
    logic [7:0] sl_len, sl_byte, reg_rdata, slice_mode, vo_data;
    int         miscompares, check_count, taken, cfg_seen;
    logic [7:0] ra[10] = '{8'hc8, 8'hc9, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hcf,
                           8'hc6, 8'hc7, 8'h10};
    logic [7:0] rv[10] = '{8'h80, 8'h00, 8'h00, 8'h4e, 8'h00, 8'h01, 8'h00,
                           8'h40, 8'h00, 8'h00};
    logic [7:0] pay[6] = '{8'h05, 8'h03, 8'h10, 8'h11, 8'h12, 8'h00};
    logic [8:0] lv[4] = '{9'h083, 9'h081, 9'h043, 9'h143};
    logic       le[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    logic [31:0] mv[4] = '{32'h01ff0127, 32'h01ff0027, 32'h00ff00ff,
                           32'h01360136};

    vsfsc_top uut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .irq_en(irq_en), .irq_thr_sts(irq_thr_sts),
        .irq_line_sts(irq_line_sts), .irq_req(irq_req), .vid_clk(vid_clk),
        .hsync_n(hsync_n), .vsync_n(vsync_n), .field_two(field_two),
        .sl_hdr(sl_hdr), .sl_svc(sl_svc), .sl_len(sl_len), .sl_dv(sl_dv),
        .sl_byte(sl_byte), .line_mode(line_mode), .ff_mode(ff_mode),
        .in_vblank(in_vblank), .slice_mode(slice_mode),
        .cfg_load(cfg_load), .res_clear(res_clear), .vo_data(vo_data),
        .vo_valid(vo_valid), .vo_ready(vo_ready));
    vsfsc_slicer_model slc (.vid_clk(vid_clk), .hsync_n(hsync_n),
        .vsync_n(vsync_n), .field_two(field_two), .sl_hdr(sl_hdr),
        .sl_svc(sl_svc), .sl_len(sl_len), .sl_dv(sl_dv), .sl_byte(sl_byte));

    always #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (vo_valid && vo_ready)
            taken++;
        if (cfg_load)
            cfg_seen++;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        @(negedge clk_sys);
        rd_v = reg_rdata;
        `CHK(rd_v, e)
    endtask
    task automatic finish_test;
        if (miscompares == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        nrst = 1'b0;
        {reg_wr, reg_rd, in_vblank, vo_ready} = 4'h0;
        {reg_addr, reg_wdata, line_mode, ff_mode} = 32'h0000ff27;
        irq_en = 8'h04;
        repeat (12) @(negedge clk_sys);
        nrst = 1'b1;
        foreach (ra[i]) rchk(ra[i], rv[i]);
        // One short line, read back byte by byte over the register port
        slc.send_line(3'd5, 8'd3, 8'h10);
        rchk(vsfsc_pkg::ADDR_WORD_COUNT, 8'h03);
        rchk(vsfsc_pkg::ADDR_STATUS, 8'h20);
        foreach (pay[i]) rchk(vsfsc_pkg::ADDR_FIFO_DATA, pay[i]);
        rchk(vsfsc_pkg::ADDR_STATUS, 8'h60);
        wr(vsfsc_pkg::ADDR_STATUS, 8'h20);
        rchk(vsfsc_pkg::ADDR_STATUS, 8'h40);
        for (int s = 0; s < 6; s++) slc.send_line(3'(s), 8'd0, 8'h00);
        rchk(vsfsc_pkg::ADDR_STATUS, 8'h3f);
        wr(vsfsc_pkg::ADDR_STATUS, 8'h01);
        rchk(vsfsc_pkg::ADDR_STATUS, 8'h3e);
        wr(vsfsc_pkg::ADDR_FLUSH, 8'h5a);
        rchk(vsfsc_pkg::ADDR_STATUS, 8'h40);
        rchk(vsfsc_pkg::ADDR_WORD_COUNT, 8'h00);
        // Fill to the threshold boundary, overflow, then a line that fits
        slc.send_line(3'd5, 8'd254, 8'h00);
        `CHK(irq_thr_sts, 1'b0)
        slc.send_line(3'd5, 8'd250, 8'h00);
        slc.send_line(3'd5, 8'd254, 8'h00);
        rchk(vsfsc_pkg::ADDR_WORD_COUNT, 8'hfe);
        slc.send_line(3'd1, 8'd2, 8'h00);
        rchk(vsfsc_pkg::ADDR_STATUS, 8'ha2);
        rchk(vsfsc_pkg::ADDR_WORD_COUNT, 8'hff);
        `CHK(irq_req, 1'b1)
        wr(vsfsc_pkg::ADDR_IRQ_STATUS, 8'h04);
        `CHK(irq_thr_sts, 1'b1)
        irq_en = 8'h00;
        #1 `CHK(irq_req, 1'b0)
        // Stream to the video lane with the receiver stalling first
        wr(vsfsc_pkg::ADDR_OUT_SEL, 8'h00);
        repeat (8) @(negedge clk_sys);
        `CHK(vo_data, 8'h05)
        vo_ready = 1'b1;
        for (int i = 0; i < 3000 && taken < 512; i++) @(negedge clk_sys);
        `CHK(taken, 512)
        `CHK(vo_valid, 1'b0)
        rchk(vsfsc_pkg::ADDR_STATUS, 8'he2);
        wr(vsfsc_pkg::ADDR_IRQ_STATUS, 8'h04);
        `CHK(irq_thr_sts, 1'b0)
        wr(vsfsc_pkg::ADDR_OUT_SEL, 8'h01);
        // Line match per field; switch pixel inside a 16-pixel line
        irq_en = 8'h02;
        wr(vsfsc_pkg::ADDR_SWPIX_LO, 8'h05);
        wr(vsfsc_pkg::ADDR_SWPIX_HI, 8'h00);
        // One line first, so the free pixel count cannot pass the switch
        slc.scan_field(1'b0, 1);
        cfg_seen = 0;
        foreach (lv[i]) begin
            wr(vsfsc_pkg::ADDR_IRQ_STATUS, 8'h02);
            wr(vsfsc_pkg::ADDR_LINE_INT, lv[i][7:0]);
            slc.scan_field(lv[i][8], 3);
            `CHK(irq_line_sts, le[i])
            `CHK(irq_req, le[i])
        end
        `CHK(cfg_seen, 12)
        foreach (mv[i]) begin
            wr(vsfsc_pkg::ADDR_FULL_FIELD, mv[i][31:24]);
            line_mode = mv[i][23:16];
            in_vblank = mv[i][8];
            repeat (2) @(negedge clk_sys);
            `CHK(slice_mode, mv[i][7:0])
        end
        finish_test;
    end

    initial begin
        #2ms;
        miscompares++;
        finish_test;
    end
endmodule
